// ==== design/ial_pkg.sv ====
/*
 * shared constants and carrier types for the increment / or-literal
 * datapath.
 * assumes an 8-bit core with a single clock and a register file that
 * answers a read address in the same cycle.
 */
package ial_pkg;

    localparam int          DATA_W      = 8;
    localparam logic        DEST_W      = 1'b0;  // result to accumulator
    localparam logic        DEST_F      = 1'b1;  // result back to file
    localparam logic [7:0]  W_RST       = 8'h00;
    localparam logic [7:0]  ADDR_RST    = 8'h00;
    localparam logic [7:0]  DATA_ALL1   = 8'hff;
    localparam logic [7:0]  DATA_ZERO   = 8'h00;

    // instruction selector handed over by decode
    typedef enum logic [1:0]
    {
        increment_file_op              = 2'h0,
        increment_skip_on_zero_op      = 2'h1,
        or_literal_into_accumulator_op = 2'h2
    } ial_op_t;

    // sequencer states, gray along idle -> read -> nop
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_NOP  = 2'b11
    } ial_state_t;

    typedef struct packed
    {
        ial_op_t     op;
        logic [7:0]  addr;
        logic        dest;
        logic [7:0]  lit;
    } ial_req_t;

    typedef struct packed
    {
        logic        we;
        logic [7:0]  addr;
        logic [7:0]  data;
    } ial_fwr_t;

endpackage : ial_pkg

// ==== design/ial_incr.sv ====
/*
 * wrapping incrementer with zero detect.
 * assumes its operand is stable for the cycle; purely combinational.
 */
`timescale 1ns/1ps
module ial_incr
#(
    parameter int WIDTH = ial_pkg::DATA_W
)
(
    input  wire logic [WIDTH-1:0] operand,
    output wire logic [WIDTH-1:0] sum,
    output wire logic             is_zero
);
    import ial_pkg::*;

    // carry out is dropped on purpose so all ones wraps to zero
    assign sum     = WIDTH'(operand + 1'b1);
    assign is_zero = (sum == '0);

endmodule : ial_incr

// ==== design/ial_core.sv ====
/*
 * execution datapath for increment-file, increment-skip-on-zero and
 * or-literal-into-accumulator. holds the accumulator and drives file
 * writes, the zero flag update and the skip request to fetch.
 * assumes decode holds req stable while req_valid is high and the
 * register file returns file_rd_data combinationally from file_rd_addr.
 */
`timescale 1ns/1ps
module ial_core
(
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              req_valid,
    input  wire ial_pkg::ial_req_t req,
    output logic                   req_ready,
    output logic [7:0]             file_rd_addr,
    input  wire logic [7:0]        file_rd_data,
    output ial_pkg::ial_fwr_t      file_wr,
    output logic [7:0]             w_data,
    output logic                   zero_we,
    output logic                   zero_val,
    output logic                   skip_next,
    output logic                   done
);
    import ial_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // state and registers

    ial_state_t  state_q;
    ial_state_t  state_d;
    logic        ready_q;
    ial_op_t     op_q;
    logic        dest_q;
    logic [7:0]  addr_q;
    logic [7:0]  w_q;
    logic [7:0]  w_d;
    ial_fwr_t    fwr_q;
    ial_fwr_t    fwr_d;
    logic        zwe_q;
    logic        zval_q;
    logic        skip_q;
    logic        done_q;

    ////////////////////////////////////////////////////////////////////
    // decode and datapath

    wire         take;
    wire         take_or;
    wire         in_read;
    wire         is_skip_op;
    wire         do_skip;
    wire [7:0]   req_lit;
    wire [7:0]   or_res;
    wire [7:0]   incr_sum;
    wire         incr_zero;

    // requests are only taken while idle, so decode stalls on req_ready
    assign take       = req_valid & ready_q;
    assign take_or    = take & (req.op == or_literal_into_accumulator_op);
    assign in_read    = (state_q == ST_READ);
    assign is_skip_op = (op_q == increment_skip_on_zero_op);
    assign do_skip    = in_read & is_skip_op & incr_zero;
    assign req_lit    = req.lit;
    assign or_res     = w_q | req_lit;

    // the file operand is read one cycle after the address is latched
    ial_incr
    #(
        .WIDTH   (DATA_W)
    )
    ial_incr_inst
    (
        .operand (file_rd_data),
        .sum     (incr_sum),
        .is_zero (incr_zero)
    );

    // next state: literal op never leaves idle, skip adds a nop cycle
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:
            begin
                if (take && !take_or)
                    state_d = ST_READ;
            end
            ST_READ:
            begin
                state_d = do_skip ? ST_NOP : ST_IDLE;
            end
            ST_NOP:
            begin
                state_d = ST_IDLE;
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // accumulator and file write selection by destination bit
    always_comb
    begin
        w_d  = w_q;
        fwr_d = '{we: 1'b0, addr: addr_q, data: incr_sum};
        if (take_or)
            w_d = or_res;
        else if (in_read && dest_q == DEST_W)
            w_d = incr_sum;
        if (in_read && dest_q == DEST_F)
            fwr_d.we = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // registers

    // sequencer and request capture
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= ST_IDLE;
            ready_q <= 1'b1;
            op_q    <= increment_file_op;
            dest_q  <= DEST_W;
            addr_q  <= ADDR_RST;
        end
        else
        begin
            state_q <= state_d;
            ready_q <= (state_d == ST_IDLE);
            if (take)
            begin
                op_q   <= req.op;
                dest_q <= req.dest;
                addr_q <= req.addr;
            end
        end
    end

    // results; only the or-literal op reaches the zero flag
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            w_q    <= W_RST;
            fwr_q  <= '{we: 1'b0, addr: ADDR_RST, data: DATA_ZERO};
            zwe_q  <= 1'b0;
            zval_q <= 1'b0;
            skip_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            w_q    <= w_d;
            fwr_q  <= fwr_d;
            zwe_q  <= take_or;
            zval_q <= (or_res == DATA_ZERO);
            skip_q <= do_skip;
            done_q <= take_or | in_read;
        end
    end

    assign req_ready    = ready_q;
    assign file_rd_addr = addr_q;
    assign file_wr      = fwr_q;
    assign w_data       = w_q;
    assign zero_we      = zwe_q;
    assign zero_val     = zval_q;
    assign skip_next    = skip_q;
    assign done         = done_q;

    ////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_zero_skip;
        in_read && is_skip_op && incr_zero;
    endsequence

    sequence s_nop_then_idle;
        skip_q && !ready_q ##1 !skip_q && ready_q;
    endsequence

    incr_result_a : assert property (
        in_read |=> done_q &&
            ((fwr_q.we ? fwr_q.data : w_q) == 8'($past(file_rd_data) + 1)))
        else $error("increment result is not operand plus one");

    dest_accum_a : assert property (
        in_read && dest_q == DEST_W |=> !fwr_q.we && w_q == $past(incr_sum))
        else $error("destination 0 did not write the accumulator");

    dest_file_a : assert property (
        in_read && dest_q == DEST_F
            |=> fwr_q.we && fwr_q.addr == $past(addr_q) && $stable(w_q))
        else $error("destination 1 did not write the file register");

    skip_flags_a : assert property (
        in_read && is_skip_op |=> !zero_we)
        else $error("increment-skip touched the zero flag");

    skip_two_a : assert property (
        s_zero_skip |=> s_nop_then_idle)
        else $error("zero result did not insert one nop cycle");

    no_skip_a : assert property (
        in_read && !(is_skip_op && incr_zero) |=> ready_q && !skip_q)
        else $error("nonzero result did not finish in one cycle");

    or_literal_a : assert property (
        take_or |=> w_q == ($past(w_q) | $past(req_lit)) && zero_we &&
            zero_val == (w_q == DATA_ZERO) && ready_q && done_q)
        else $error("or-literal result or zero flag wrong");

    wrap_zero_a : assert property (
        in_read && is_skip_op && file_rd_data == DATA_ALL1 |=> skip_q)
        else $error("all ones operand did not wrap and skip");

endmodule : ial_core

// ==== bench/tb_ial_core.sv ====
/*
 * self-checking bench for the increment / or-literal datapath.
 * assumes the bench plays decode and the register file on one clock.
 */
`timescale 1ns/1ps
module tb_ial_core;
    import ial_pkg::*;

    logic              clk          = 1'b0;
    logic              reset_n      = 1'b0;
    logic              req_valid    = 1'b0;
    ial_req_t          req          = '0;
    logic              req_ready;
    logic [7:0]        file_rd_addr;
    logic [7:0]        file_rd_data = 8'h00;
    ial_fwr_t          file_wr;
    logic [7:0]        w_data;
    logic              zero_we;
    logic              zero_val;
    logic              skip_next;
    logic              done;
    int                n_fail       = 0;
    int                check_count  = 0;

    ////////////////////////////////////////////////////////////////////////
    // 125 MHz core clock
    always #4 clk = ~clk;

    ial_core ial_core_inst
    (
        .clk          (clk),
        .reset_n      (reset_n),
        .req_valid    (req_valid),
        .req          (req),
        .req_ready    (req_ready),
        .file_rd_addr (file_rd_addr),
        .file_rd_data (file_rd_data),
        .file_wr      (file_wr),
        .w_data       (w_data),
        .zero_we      (zero_we),
        .zero_val     (zero_val),
        .skip_next    (skip_next),
        .done         (done)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // one instruction: wait for idle, present it, watch four cycles;
    // packs done cycle, skip cycle, busy cycles, w, file write, flag,
    // read address
    task automatic run_op(input ial_op_t op, input logic [7:0] a,
                          input logic d, input logic [7:0] l,
                          input logic [7:0] rd, input logic [7:0] ew,
                          input logic ewe, input logic [7:0] efd,
                          input logic ezw, input logic ezv,
                          input logic esk);
        logic [2:0] dn;
        logic [2:0] sk;
        logic [2:0] nr;
        logic [7:0] w;
        logic [7:0] ra;
        ial_fwr_t   fw;
        logic       zw;
        logic       zv;
        logic       is_or;
        int         i;
        dn    = 3'h0;
        sk    = 3'h0;
        nr    = 3'h0;
        w     = 8'h00;
        ra    = 8'h00;
        fw    = '0;
        zw    = 1'b0;
        zv    = 1'b0;
        is_or = (op == or_literal_into_accumulator_op);
        for (i = 0; i < 10 && req_ready !== 1'b1; i++)
            @(negedge clk);
        if (req_ready !== 1'b1)
        begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, req_ready, 1'b1);
            finish_test();
        end
        else
        begin
            @(posedge clk);
            req_valid    <= 1'b1;
            req          <= '{op: op, addr: a, dest: d, lit: l};
            file_rd_data <= rd;
            @(posedge clk);
            req_valid    <= 1'b0;
            // the decode request is taken at this edge, count from it
            for (i = 1; i <= 4; i++)
            begin
                @(negedge clk);
                if (done === 1'b1)
                begin
                    dn = 3'(i);
                    w  = w_data;
                    ra = file_rd_addr;
                end
                // skip pulse shares the cycle with done
                if (skip_next === 1'b1)
                    sk = 3'(i);
                // an unknown ready counts as busy, so it cannot slip by
                if (req_ready !== 1'b1)
                    nr = nr + 3'h1;
                if (file_wr.we === 1'b1)
                    fw = file_wr;
                if (zero_we === 1'b1)
                begin
                    zw = 1'b1;
                    zv = zero_val;
                end
            end
            // or-literal has no file read, so its read address is not judged;
            // increments stay busy one cycle, two when the skip adds a nop
            chk({dn, sk, nr, w, fw, zw, zv, is_or ? 8'h00 : ra},
                {is_or ? 3'h1 : 3'h2, esk ? 3'h2 : 3'h0,
                 is_or ? 3'h0 : (esk ? 3'h2 : 3'h1), ew,
                 ewe ? {1'b1, a, efd} : 17'h0, ezw, ezw & ezv,
                 is_or ? 8'h00 : a});
        end
    endtask : run_op

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk({req_ready, w_data, done, skip_next, zero_we, file_wr.we},
            {1'b1, W_RST, 4'h0});
        $display("test reset done");
    endtask : t_reset

    task automatic t_or_lit;
        run_op(or_literal_into_accumulator_op, 8'h00, 0, 8'h00, 8'h00,
               8'h00, 0, 8'h00, 1, 1, 0);
        run_op(or_literal_into_accumulator_op, 8'h00, 0, 8'h69, 8'h00,
               8'h69, 0, 8'h00, 1, 0, 0);
        run_op(or_literal_into_accumulator_op, 8'h00, 0, 8'h85, 8'h00,
               8'hed, 0, 8'h00, 1, 0, 0);
        $display("test or literal done");
    endtask : t_or_lit

    task automatic t_inc_file;
        run_op(increment_file_op, 8'h11, DEST_W, 8'h00, 8'h23,
               8'h24, 0, 8'h00, 0, 0, 0);
        run_op(increment_file_op, 8'h5a, DEST_F, 8'h00, 8'h23,
               8'h24, 1, 8'h24, 0, 0, 0);
        run_op(increment_file_op, 8'hff, DEST_F, 8'h00, DATA_ALL1,
               8'h24, 1, 8'h00, 0, 0, 0);
        $display("test increment file done");
    endtask : t_inc_file

    task automatic t_inc_skip;
        run_op(increment_skip_on_zero_op, 8'h01, DEST_W, 8'h00, DATA_ALL1,
               8'h00, 0, 8'h00, 0, 0, 1);
        run_op(increment_skip_on_zero_op, 8'h3c, DEST_F, 8'h00, 8'h7f,
               8'h00, 1, 8'h80, 0, 0, 0);
        run_op(increment_skip_on_zero_op, 8'hc3, DEST_F, 8'h00, DATA_ALL1,
               8'h00, 1, 8'h00, 0, 0, 1);
        $display("test increment skip done");
    endtask : t_inc_skip

    ////////////////////////////////////////////////////////////////////////
    // reset held five cycles, then the scenarios in turn
    initial
    begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        t_reset();
        t_or_lit();
        t_inc_file();
        t_inc_skip();
        finish_test();
    end

endmodule : tb_ial_core
